// ==== uifs_consts.svh ====
// Constants for the UART queue interrupt and line status block.
`ifndef UIFS_CONSTS_SVH
`define UIFS_CONSTS_SVH

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define UIFS_OFF_DATA 8'h00
`define UIFS_OFF_IRQ_EN 8'h04
`define UIFS_OFF_INT_ID 8'h08
`define UIFS_OFF_QCTRL 8'h0c
`define UIFS_OFF_LINE_CFG 8'h10
`define UIFS_OFF_LINE_STATE 8'h14

// -----------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------
`define UIFS_QCTRL_FIFO_BIT 0
`define UIFS_QCTRL_TRIG_LSB 6
`define UIFS_CFG_BITS_RST 4'ha
`define UIFS_IRQ_EN_RST 4'h0
`define UIFS_TRIG_RST 2'h0

// -----------------------------------------------------------------
// Identification codes
// -----------------------------------------------------------------
`define UIFS_ID_NONE 4'h1
`define UIFS_ID_LINE 4'h6
`define UIFS_ID_RDA 4'h4
`define UIFS_ID_TOUT 4'hc
`define UIFS_ID_TX_HOLDING_EMPTY 4'h2
`define UIFS_ID_MODEM 4'h0
`define UIFS_ID_FIFO_MARK 4'hc

// -----------------------------------------------------------------
// Timing in baud ticks (ticks run at sixteen per bit)
// -----------------------------------------------------------------
`define UIFS_TICKS_PER_BIT 11'h010
`define UIFS_TIMEOUT_CHARS 11'h004

// -----------------------------------------------------------------
// Trigger levels
// -----------------------------------------------------------------
`define UIFS_TRIG_L0 5'h01
`define UIFS_TRIG_L1 5'h04
`define UIFS_TRIG_L2 5'h08
`define UIFS_TRIG_L3 5'h0e

// -----------------------------------------------------------------
// Bus answers
// -----------------------------------------------------------------
`define UIFS_RESP_OKAY 2'h0
`define UIFS_RESP_SLVERR 2'h2

`endif

// ==== uifs_far.sv ====
// Model of the transmit shift register and baud tick beside the queue logic.
module uifs_far (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Transmit queue side.
  input wire logic tx_pop_valid,
  input wire logic [7:0] tx_pop_data,
  output logic tx_pop_ready,
  output logic tx_shift_busy,
  // Baud tick and the last two bytes shifted out.
  output logic baud_tick_output,
  output logic [15:0] sent_log
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] busy_cnt;

  // The shifter takes a byte only when idle, so bytes can pile up.
  assign tx_shift_busy = busy_cnt != 9'h000;
  assign tx_pop_ready = !tx_shift_busy;

  // A tick every other cycle keeps timeouts short but not trivial.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_tick_output <= 1'b0;
    end else begin
      baud_tick_output <= !baud_tick_output;
    end
  end

  // Each byte occupies the shifter for 200 cycles.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_cnt <= 9'h000;
      sent_log <= 16'h0000;
    end else if (tx_pop_valid && tx_pop_ready) begin
      busy_cnt <= 9'h0c8;
      sent_log <= {sent_log[7:0], tx_pop_data};
    end else if (tx_shift_busy) begin
      busy_cnt <= busy_cnt - 9'h001;
    end
  end
endmodule // uifs_far

// ==== uifs_pkg.sv ====
// Types shared by the UART queue interrupt and line status block.
package uifs_pkg;

  // One received character with its error bits.
  typedef struct packed {
    logic brk;
    logic framing;
    logic parity;
    logic [7:0] data;
  } uifs_rx_char_t;

  // Interrupt enable bits.
  typedef struct packed {
    logic modem_status_irq_enable;
    logic line_status_irq_enable;
    logic tx_empty_irq_enable;
    logic rx_data_irq_enable;
  } uifs_ier_t;

  // Line state register layout.
  typedef struct packed {
    logic rx_queue_error_flag;
    logic transmitter_idle_flag;
    logic tx_queue_empty_flag;
    logic brk;
    logic framing;
    logic parity;
    logic overrun;
    logic data_ready_flag;
  } uifs_lsr_t;

endpackage

// ==== uifs_top.sv ====
// Queue interrupt and line status logic of one UART channel.
`include "uifs_consts.svh"

module uifs_top
  import uifs_pkg::*;
#(
  parameter int QUEUE_DEPTH = 16
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Baud output tick, sixteen per bit, from the baud generator.
  input wire logic baud_tick_output,
  // Receive shift register side.
  input wire logic rx_push_valid,
  input wire uifs_rx_char_t rx_push_char,
  // Transmit shift register side.
  output logic tx_pop_valid,
  input wire logic tx_pop_ready,
  output logic [7:0] tx_pop_data,
  input wire logic tx_shift_busy,
  // Modem change summary and channel interrupt.
  input wire logic modem_delta,
  output logic irq
);

  localparam int AW = $clog2(QUEUE_DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(QUEUE_DEPTH);

  // Trigger level decode; used by the interrupt and the assertions.
  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'h0: trig_level = `UIFS_TRIG_L0;
      2'h1: trig_level = `UIFS_TRIG_L1;
      2'h2: trig_level = `UIFS_TRIG_L2;
      default: trig_level = `UIFS_TRIG_L3;
    endcase
  endfunction

  // -----------------------------------------------------------------
  // Registers and handshake terms
  // -----------------------------------------------------------------
  uifs_ier_t ier_reg;
  logic fifo_en_reg;
  logic [1:0] trig_sel_reg;
  logic [3:0] char_bits_reg;
  logic wr_go, rd_go;
  logic wr_data, wr_ier, wr_qctrl, wr_cfg, wr_ok;
  logic rd_data, rd_iid, rd_lsr, rd_ok;
  logic flush;
  logic [31:0] rd_value;

  // Write address and data are taken together, one write at a time.
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign rd_go = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rd_go;

  assign wr_data = wr_go && s_axi_awaddr == `UIFS_OFF_DATA && s_axi_wstrb[0];
  assign wr_ier = wr_go && s_axi_awaddr == `UIFS_OFF_IRQ_EN && s_axi_wstrb[0];
  assign wr_qctrl = wr_go && s_axi_awaddr == `UIFS_OFF_QCTRL && s_axi_wstrb[0];
  assign wr_cfg = wr_go && s_axi_awaddr == `UIFS_OFF_LINE_CFG
                  && s_axi_wstrb[0];
  assign wr_ok = s_axi_awaddr == `UIFS_OFF_DATA
              || s_axi_awaddr == `UIFS_OFF_IRQ_EN
              || s_axi_awaddr == `UIFS_OFF_QCTRL
              || s_axi_awaddr == `UIFS_OFF_LINE_CFG;
  assign rd_data = rd_go && s_axi_araddr == `UIFS_OFF_DATA;
  assign rd_iid = rd_go && s_axi_araddr == `UIFS_OFF_INT_ID;
  assign rd_lsr = rd_go && s_axi_araddr == `UIFS_OFF_LINE_STATE;
  // Toggling the queue enable empties both queues, as on the real part.
  assign flush = wr_qctrl
              && s_axi_wdata[`UIFS_QCTRL_FIFO_BIT] != fifo_en_reg;

  // Control registers written by software.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ier_reg <= `UIFS_IRQ_EN_RST;
      fifo_en_reg <= 1'b0;
      trig_sel_reg <= `UIFS_TRIG_RST;
      char_bits_reg <= `UIFS_CFG_BITS_RST;
    end else begin
      if (wr_ier) begin
        ier_reg <= uifs_ier_t'(s_axi_wdata[3:0]);
      end
      if (wr_qctrl) begin
        fifo_en_reg <= s_axi_wdata[`UIFS_QCTRL_FIFO_BIT];
        trig_sel_reg <= s_axi_wdata[`UIFS_QCTRL_TRIG_LSB +: 2];
      end
      if (wr_cfg) begin
        char_bits_reg <= s_axi_wdata[3:0];
      end
    end
  end

  // -----------------------------------------------------------------
  // Receive queue
  // -----------------------------------------------------------------
  uifs_rx_char_t rx_mem [QUEUE_DEPTH];
  logic [AW-1:0] rx_wp_reg, rx_rp_reg;
  logic [AW:0] rx_cnt_reg, rx_err_cnt_reg;
  logic rx_push, rx_pop, rx_full, push_err, pop_err;
  uifs_rx_char_t rx_head;

  assign rx_full = rx_cnt_reg == DEPTH_C;
  assign rx_push = rx_push_valid && !rx_full && !flush;
  assign rx_pop = rd_data && rx_cnt_reg != '0 && !flush;
  assign rx_head = rx_mem[rx_rp_reg];
  assign push_err = |{rx_push_char.brk, rx_push_char.framing,
                      rx_push_char.parity};
  assign pop_err = |{rx_head.brk, rx_head.framing, rx_head.parity};

  // Storage is written without reset; only pointers and counts carry state.
  always_ff @(posedge aclk) begin
    if (rx_push) begin
      rx_mem[rx_wp_reg] <= rx_push_char;
    end
  end

  // Pointers, count and a count of errored entries.
  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      rx_wp_reg <= '0;
      rx_rp_reg <= '0;
      rx_cnt_reg <= '0;
      rx_err_cnt_reg <= '0;
    end else begin
      if (rx_push) begin
        rx_wp_reg <= rx_wp_reg + 1'b1;
      end
      if (rx_pop) begin
        rx_rp_reg <= rx_rp_reg + 1'b1;
      end
      rx_cnt_reg <= rx_cnt_reg + (AW + 1)'(rx_push) - (AW + 1)'(rx_pop);
      rx_err_cnt_reg <= rx_err_cnt_reg + (AW + 1)'(rx_push && push_err)
                        - (AW + 1)'(rx_pop && pop_err);
    end
  end

  // Overrun is sticky until the line state is read; a new one wins.
  logic overrun_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_reg <= 1'b0;
    end else if (rx_push_valid && rx_full) begin
      overrun_reg <= 1'b1;
    end else if (rd_lsr) begin
      overrun_reg <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Receive timeout, counted in baud ticks
  // -----------------------------------------------------------------
  logic [10:0] to_cnt_reg, to_limit;
  logic to_flag_reg, to_restart;

  assign to_limit = `UIFS_TIMEOUT_CHARS * `UIFS_TICKS_PER_BIT
                    * {7'h00, char_bits_reg};
  // Once active only a read restarts it; while idle a push does too.
  assign to_restart = rx_pop || (rx_push && !to_flag_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      to_cnt_reg <= '0;
      to_flag_reg <= 1'b0;
    end else if (to_restart || rx_cnt_reg == '0) begin
      to_cnt_reg <= '0;
      to_flag_reg <= 1'b0;
    end else if (to_cnt_reg >= to_limit) begin
      to_flag_reg <= 1'b1;
    end else if (baud_tick_output) begin
      to_cnt_reg <= to_cnt_reg + 11'h001;
    end
  end

  // -----------------------------------------------------------------
  // Transmit queue
  // -----------------------------------------------------------------
  logic [7:0] tx_mem [QUEUE_DEPTH];
  logic [AW-1:0] tx_wp_reg, tx_rp_reg;
  logic [AW:0] tx_cnt_reg;
  logic tx_push, tx_pop;

  assign tx_push = wr_data && tx_cnt_reg != DEPTH_C && !flush;
  assign tx_pop = tx_pop_valid && tx_pop_ready;
  assign tx_pop_valid = tx_cnt_reg != '0;
  assign tx_pop_data = tx_mem[tx_rp_reg];

  // Holding register writes land in the transmit queue.
  always_ff @(posedge aclk) begin
    if (tx_push) begin
      tx_mem[tx_wp_reg] <= s_axi_wdata[7:0];
    end
  end

  // Pointers and count of the transmit queue.
  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      tx_wp_reg <= '0;
      tx_rp_reg <= '0;
      tx_cnt_reg <= '0;
    end else begin
      if (tx_push) begin
        tx_wp_reg <= tx_wp_reg + 1'b1;
      end
      if (tx_pop) begin
        tx_rp_reg <= tx_rp_reg + 1'b1;
      end
      tx_cnt_reg <= tx_cnt_reg + (AW + 1)'(tx_push) - (AW + 1)'(tx_pop);
    end
  end

  // -----------------------------------------------------------------
  // Transmit empty indication with its delay
  // -----------------------------------------------------------------
  logic tx_empty_ind_reg, two_seen_reg, skip_delay_reg, dly_run_reg;
  logic [10:0] dly_cnt_reg, dly_len;
  logic empty_set, go_empty;

  // One character minus its final stop bit.
  assign dly_len = `UIFS_TICKS_PER_BIT * ({7'h00, char_bits_reg} - 11'h001);
  assign go_empty = tx_cnt_reg == '0 && !tx_empty_ind_reg && !tx_push;
  // Without two bytes ever queued together the shifter has only just
  // taken the sole byte; waiting avoids a second interrupt at once.
  assign empty_set = go_empty && (two_seen_reg || skip_delay_reg
                     || (dly_run_reg && dly_cnt_reg == '0));

  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      tx_empty_ind_reg <= 1'b1;
      dly_run_reg <= 1'b0;
      dly_cnt_reg <= '0;
    end else if (tx_push) begin
      tx_empty_ind_reg <= 1'b0;
      dly_run_reg <= 1'b0;
    end else if (empty_set) begin
      tx_empty_ind_reg <= 1'b1;
      dly_run_reg <= 1'b0;
    end else if (go_empty && !dly_run_reg) begin
      dly_run_reg <= 1'b1;
      dly_cnt_reg <= dly_len;
    end else if (dly_run_reg && baud_tick_output) begin
      dly_cnt_reg <= dly_cnt_reg - 11'h001;
    end
  end

  // Two-byte history and the skip after an enable change.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      two_seen_reg <= 1'b0;
      skip_delay_reg <= 1'b0;
    end else begin
      if (tx_cnt_reg >= (AW + 1)'(2)) begin
        two_seen_reg <= 1'b1;
      end else if (empty_set) begin
        two_seen_reg <= 1'b0;
      end
      if (flush) begin
        skip_delay_reg <= 1'b1;
      end else if (empty_set) begin
        skip_delay_reg <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // Interrupt sources and identification
  // -----------------------------------------------------------------
  logic tx_holding_empty_pend_reg, rda_irq, tout_irq, line_irq, tx_holding_empty_irq, modem_irq;
  logic [3:0] iid_code;
  uifs_lsr_t line_state_register;

  // Flush also sets the indication, so the skip lets it fire at once.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_holding_empty_pend_reg <= 1'b0;
    end else if (empty_set || flush) begin
      tx_holding_empty_pend_reg <= 1'b1;
    end else if (wr_data || (rd_iid && iid_code == `UIFS_ID_TX_HOLDING_EMPTY)) begin
      tx_holding_empty_pend_reg <= 1'b0;
    end
  end

  assign line_state_register.data_ready_flag = rx_cnt_reg != '0;
  assign line_state_register.overrun = overrun_reg;
  assign line_state_register.parity = line_state_register.data_ready_flag && rx_head.parity;
  assign line_state_register.framing = line_state_register.data_ready_flag && rx_head.framing;
  assign line_state_register.brk = line_state_register.data_ready_flag && rx_head.brk;
  assign line_state_register.tx_queue_empty_flag = tx_empty_ind_reg;
  assign line_state_register.transmitter_idle_flag = tx_empty_ind_reg
                                     && !tx_shift_busy;
  assign line_state_register.rx_queue_error_flag = rx_err_cnt_reg != '0;

  // Polled operation simply leaves these gates closed.
  assign rda_irq = ier_reg.rx_data_irq_enable && (fifo_en_reg
                   ? rx_cnt_reg >= trig_level(trig_sel_reg)
                   : rx_cnt_reg != '0);
  assign tout_irq = ier_reg.rx_data_irq_enable && fifo_en_reg
                    && to_flag_reg;
  assign line_irq = ier_reg.line_status_irq_enable
                    && (line_state_register.overrun || line_state_register.parity || line_state_register.framing
                        || line_state_register.brk);
  assign tx_holding_empty_irq = ier_reg.tx_empty_irq_enable && tx_holding_empty_pend_reg;
  assign modem_irq = ier_reg.modem_status_irq_enable && modem_delta;

  // Line status first, then receive, then timeout, then holding empty, then modem.
  always_comb begin
    if (line_irq) begin
      iid_code = `UIFS_ID_LINE;
    end else if (rda_irq) begin
      iid_code = `UIFS_ID_RDA;
    end else if (tout_irq) begin
      iid_code = `UIFS_ID_TOUT;
    end else if (tx_holding_empty_irq) begin
      iid_code = `UIFS_ID_TX_HOLDING_EMPTY;
    end else if (modem_irq) begin
      iid_code = `UIFS_ID_MODEM;
    end else begin
      iid_code = `UIFS_ID_NONE;
    end
  end

  // Interrupt pin held in a flop so it never glitches.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= iid_code != `UIFS_ID_NONE;
    end
  end

  // -----------------------------------------------------------------
  // Read mux and bus answers
  // -----------------------------------------------------------------
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `UIFS_OFF_DATA: rd_value[10:0] = rx_head;
      `UIFS_OFF_IRQ_EN: rd_value[3:0] = ier_reg;
      `UIFS_OFF_INT_ID: begin
        rd_value[3:0] = iid_code;
        rd_value[7:4] = fifo_en_reg ? `UIFS_ID_FIFO_MARK : 4'h0;
      end
      `UIFS_OFF_QCTRL: begin
        rd_value[`UIFS_QCTRL_FIFO_BIT] = fifo_en_reg;
        rd_value[`UIFS_QCTRL_TRIG_LSB +: 2] = trig_sel_reg;
      end
      `UIFS_OFF_LINE_CFG: rd_value[3:0] = char_bits_reg;
      `UIFS_OFF_LINE_STATE: rd_value[7:0] = line_state_register;
      default: rd_ok = 1'b0;
    endcase
  end

  // Read answer: registered data, one cycle after the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `UIFS_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_ok ? `UIFS_RESP_OKAY : `UIFS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Write answer one cycle after both channels are taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UIFS_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? `UIFS_RESP_OKAY : `UIFS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence push_into_empty_s;
    rx_push && rx_cnt_reg == '0 && !rx_pop;
  endsequence
  sequence timeout_active_read_s;
    to_flag_reg && rx_pop;
  endsequence
  sequence sole_byte_leaves_s;
    go_empty && !two_seen_reg && !skip_delay_reg && !dly_run_reg;
  endsequence

  data_ready_set_a: assert property (
    push_into_empty_s |=> line_state_register.data_ready_flag [*1] ##1 1'b1)
    else $error("data ready not set after push");
  trig_report_a: assert property (
    fifo_en_reg && ier_reg.rx_data_irq_enable && !line_irq
    && rx_cnt_reg >= trig_level(trig_sel_reg) |-> iid_code == `UIFS_ID_RDA)
    else $error("trigger level not reported");
  line_prio_a: assert property (
    line_irq |-> iid_code == `UIFS_ID_LINE)
    else $error("line status lost priority");
  tout_clear_a: assert property (
    timeout_active_read_s |=> !to_flag_reg && to_cnt_reg == '0)
    else $error("timeout not cleared by read");
  tout_restart_a: assert property (
    !to_flag_reg && (rx_push || rx_pop) |=> to_cnt_reg == '0)
    else $error("timeout timer not restarted");
  tout_cause_a: assert property (
    $rose(to_flag_reg) |-> $past(rx_cnt_reg) != '0
    && $past(to_cnt_reg) >= $past(to_limit))
    else $error("timeout raised without cause");
  tx_holding_empty_write_a: assert property (
    tx_push && !flush |=> !tx_holding_empty_pend_reg && !tx_empty_ind_reg)
    else $error("holding empty not cleared by write");
  empty_delay_a: assert property (
    sole_byte_leaves_s |=> !tx_empty_ind_reg [*2])
    else $error("empty indication not delayed");
  idle_flag_a: assert property (
    line_state_register.transmitter_idle_flag |-> tx_cnt_reg == '0 && !tx_shift_busy)
    else $error("idle flag with data pending");
  polled_quiet_a: assert property (
    !ier_reg.rx_data_irq_enable |-> iid_code != `UIFS_ID_RDA
    && iid_code != `UIFS_ID_TOUT)
    else $error("receive indication while polled");

endmodule // uifs_top

// ==== uifs_top_bench.sv ====
// Self-checking bench for the queue interrupt and line status block.
module uifs_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import uifs_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, baud_tick_output;
  logic rx_push_valid, tx_pop_valid, tx_pop_ready, tx_shift_busy;
  logic modem_delta, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, tx_pop_data;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] sent_log;
  uifs_rx_char_t rx_push_char;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;

  uifs_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .baud_tick_output,
    .rx_push_valid, .rx_push_char, .tx_pop_valid, .tx_pop_ready,
    .tx_pop_data, .tx_shift_busy, .modem_delta, .irq);
  uifs_far far_u (.aclk, .aresetn, .tx_pop_valid, .tx_pop_data,
    .tx_pop_ready, .tx_shift_busy, .baud_tick_output, .sent_log);

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] v);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  task automatic push(logic [10:0] c);
    rx_push_char <= c;
    rx_push_valid <= 1'b1;
    @(posedge aclk);
    rx_push_valid <= 1'b0;
    // A quiet cycle keeps a following push off this time step.
    @(posedge aclk);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_rx_level();
    wr(8'h0c, 32'h41);
    wr(8'h04, 32'h1);
    for (int i = 0; i < 3; i++) push(11'(i));
    rd(8'h08, d);
    chk("id below level", 32'hc1, d);
    push(11'h003);
    rd(8'h08, d);
    chk("id at level", 32'hc4, d);
    chk("irq at level", 32'h1, {31'h0, irq});
    rd(8'h00, d);
    rd(8'h08, d);
    chk("id dropped", 32'hc1, d);
    wr(8'h04, 32'h5);
    for (int i = 4; i < 18; i++) push(11'(i));
    rd(8'h08, d);
    chk("id overrun", 32'hc6, d);
    rd(8'h14, d);
    chk("lsr overrun", 32'h63, d);
    rd(8'h08, d);
    chk("id after lsr", 32'hc4, d);
    for (int i = 1; i < 17; i++) begin
      rd(8'h00, d);
      chk("rx order", 32'(i), d);
    end
    rd(8'h14, d);
    chk("lsr drained", 32'h60, d);
    $display("rx level test done");
  endtask
  task automatic t_timeout();
    wr(8'h04, 32'h1);
    push(11'h155);
    repeat (1200) @(posedge aclk);
    rd(8'h08, d);
    chk("id early", 32'hc1, d);
    repeat (200) @(posedge aclk);
    rd(8'h08, d);
    chk("id timeout", 32'hcc, d);
    rd(8'h00, d);
    rd(8'h08, d);
    chk("id cleared", 32'hc1, d);
    push(11'h1aa);
    rd(8'h14, d);
    chk("lsr error", 32'he5, d);
    rd(8'h00, d);
    wr(8'h04, 32'h0);
    for (int i = 0; i < 4; i++) push(11'(i));
    rd(8'h08, d);
    chk("id polled", 32'hc1, d);
    chk("irq polled", 32'h0, {31'h0, irq});
    $display("timeout test done");
  endtask
  task automatic t_tx();
    wr(8'h04, 32'h2);
    rd(8'h08, d);
    chk("id empty", 32'hc2, d);
    rd(8'h08, d);
    chk("id read clears", 32'hc1, d);
    wr(8'h00, 32'h5a);
    wr(8'h00, 32'ha5);
    rd(8'h14, d);
    chk("lsr busy", 32'h0, d & 32'h40);
    for (int i = 0; i < 300 && d !== 32'h61; i++) rd(8'h14, d);
    chk("lsr idle", 32'h61, d);
    chk("sent bytes", 32'h5aa5, 32'(sent_log));
    rd(8'h08, d);
    chk("id empty again", 32'hc2, d);
    // A lone byte: the empty indication waits nine bit times.
    wr(8'h00, 32'h3c);
    rd(8'h14, d);
    chk("empty delayed", 32'h0, d & 32'h20);
    repeat (200) @(posedge aclk);
    rd(8'h14, d);
    chk("empty still delayed", 32'h0, d & 32'h20);
    repeat (200) @(posedge aclk);
    rd(8'h14, d);
    chk("empty after delay", 32'h20, d & 32'h20);
    wr(8'h04, 32'h8);
    modem_delta <= 1'b1;
    rd(8'h08, d);
    chk("id modem", 32'hc0, d);
    modem_delta <= 1'b0;
    $display("tx test done");
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #25 aclk = !aclk;
  end
  // The run needs about 2400 cycles; 30000 means a hang.
  initial begin
    forever begin
      @(posedge aclk);
      cyc++;
      if (cyc == 30000) begin
        num_errors++;
        summarize();
      end
    end
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, rx_push_valid, modem_delta} = 4'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    rx_push_char = 11'h000;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h14, d);
    chk("lsr reset", 32'h60, d);
    rd(8'h40, d);
    chk("unmapped resp", 32'h2, 32'(s_axi_rresp));
    t_rx_level();
    t_timeout();
    t_tx();
    summarize();
  end
endmodule // uifs_top_bench
